/* File: hdl/sdcd_bus_if.sv */
// interface: command and address bus between controller and decoder
`timescale 1ns/1ns
interface sdcd_bus_if #(
    parameter int BANK_W = 3,
    parameter int ADDR_W = 14
);
    logic              csN;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic              cke;
    logic              odt;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;

    modport ctrl (output csN, rasN, casN, weN, cke, odt, bank, addr);
    modport dev  (input  csN, rasN, casN, weN, cke, odt, bank, addr);
endinterface : sdcd_bus_if

/* File: hdl/sdcd_controller.sv */
// controller end: drives commands, nop when idle, holds writes after self-refresh exit
`timescale 1ns/1ns
module sdcd_controller
    import sdcd_pkg::*;
#(
    parameter int BANK_W = BANK_W_DEF,
    parameter int ADDR_W = ROW_W_DEF,
    parameter int SRX_WAIT = SRX_WR_WAIT_NCK
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    sdcd_bus_if.ctrl               bus,
    input  wire sdcd_cmd_t         reqCmd,
    input  wire logic              reqValid,
    input  wire logic [BANK_W-1:0] reqBank,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic              reqOdt,
    input  wire logic              banksIdle,
    output logic                   reqReady
);
    typedef struct packed {
        logic                   cke;
        logic [3:0]             pins;
        logic                   odt;
        logic [BANK_W-1:0]      bank;
        logic [ADDR_W-1:0]      addr;
        logic [9:0]             wait_;
        logic                   asleep;
    } sdcd_ctl_t;

    sdcd_ctl_t c_q;
    sdcd_ctl_t c_d;
    logic      isWrite;
    logic      allowed;

    always_comb begin
        isWrite = (reqCmd == SDCD_WR) || (reqCmd == SDCD_WRA);
        allowed = !(isWrite && c_q.wait_ != 10'h000)
                  && !(reqCmd == SDCD_SRE && !banksIdle);
        reqReady = allowed;
        c_d = c_q;
        c_d.pins = 4'h7;
        c_d.odt = reqOdt;
        c_d.bank = '0;
        c_d.addr = '0;
        if (c_q.wait_ != 10'h000) begin
            c_d.wait_ = c_q.wait_ - 10'h001;
        end
        if (reqValid && allowed) begin
            c_d.bank = reqBank;
            c_d.addr = reqAddr;
            case (reqCmd)
                SDCD_MRS:  c_d.pins = 4'h0;
                SDCD_REF:  c_d.pins = 4'h1;
                SDCD_PRE, SDCD_PREA: c_d.pins = 4'h2;
                SDCD_ACT:  c_d.pins = 4'h3;
                SDCD_WR, SDCD_WRA: c_d.pins = 4'h4;
                SDCD_RD, SDCD_RDA: c_d.pins = 4'h5;
                SDCD_ZQCL, SDCD_ZQCS: c_d.pins = 4'h6;
                SDCD_DES:  c_d.pins = 4'hF;
                SDCD_SRE: begin
                    c_d.pins = 4'h1;
                    c_d.cke = 1'b0;
                    c_d.asleep = 1'b1;
                end
                SDCD_PDE: c_d.cke = 1'b0;
                SDCD_SRX, SDCD_PDX: begin
                    c_d.cke = 1'b1;
                    if (c_q.asleep) begin
                        c_d.wait_ = 10'(SRX_WAIT);
                    end
                    c_d.asleep = 1'b0;
                end
                default: c_d.pins = 4'h7;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            c_q <= '{cke: 1'b1, pins: 4'h7, default: '0};
        end else begin
            c_q <= c_d;
        end
    end

    assign bus.cke  = c_q.cke;
    assign bus.csN  = c_q.pins[3];
    assign bus.rasN = c_q.pins[2];
    assign bus.casN = c_q.pins[1];
    assign bus.weN  = c_q.pins[0];
    assign bus.odt  = c_q.odt;
    assign bus.bank = c_q.bank;
    assign bus.addr = c_q.addr;
endmodule : sdcd_controller

/* File: hdl/sdcd_decoder.sv */
// device end: samples the command bus and decodes each command
// Notes on behaviour
// - decode from edge-sampled strobes, cke prior/current
// - bank, row, column widths are parameters
// - reset only synchronous, never a command
// - bank address picks one of eight banks
// - all strobes low, cke high: mode set
// - write: ras high, cas/we low, A10 low
// - on-the-fly: A12 low chop four, high eight
// - write with A10 high auto-precharges bank
// - read like write but we high
// - read with A10 high auto-precharges bank
// - bursts run to completion; otfEnable input picks fixed/otf
// - nop leaves running burst unaffected
// - controller issues nop when idle
// - deselect behaves exactly like nop
// - no refresh in power-down; controller schedules
// - odt ignored by decode, off in self refresh
// - self-refresh exit taken only with sys_clk running
// - controller waits 512 cycles before write
// - valid inputs driven to defined levels
// - power-down entry/exit only with nop/deselect
// - self-refresh entry only with banks idle
`timescale 1ns/1ns
module sdcd_decoder
    import sdcd_pkg::*;
#(
    parameter int BANK_W = BANK_W_DEF,
    parameter int ROW_W  = ROW_W_DEF,
    parameter int COL_W  = COL_W_DEF
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    sdcd_bus_if.dev                 bus,
    input  wire logic               otfEnable,
    input  wire logic               fixedChop,
    output sdcd_cmd_t               cmdOut,
    output logic                    cmdValid,
    output logic [BANK_W-1:0]       cmdBank,
    output logic [ROW_W-1:0]        cmdAddr,
    output logic                    cmdAutoPre,
    output logic [3:0]              cmdBurst,
    output logic                    burstBusy,
    output sdcd_state_t             powerState,
    output logic                    odtActive,
    output logic [(1<<BANK_W)-1:0]  bankOpen
);
    typedef struct packed {
        logic                   ckePrev;
        sdcd_cmd_t              cmd;
        logic                   valid;
        logic [BANK_W-1:0]      bank;
        logic [ROW_W-1:0]       addr;
        logic                   autoPre;
        logic [3:0]             burst;
        logic [3:0]             beats;
        logic                   preAtEnd;
        logic [BANK_W-1:0]      preBank;
        sdcd_state_t            pstate;
        logic                   odtOn;
        logic [(1<<BANK_W)-1:0] open;
    } sdcd_dec_t;

    // prior cke resets high: a low start would fake an exit on the
    // first edge after reset, since the controller idles with cke up
    localparam sdcd_dec_t S_RST = '{
        ckePrev: 1'b1,
        cmd:     SDCD_DES,
        pstate:  SDCD_ST_IDLE,
        default: '0
    };

    sdcd_dec_t              s_q;
    sdcd_dec_t              s_d;
    sdcd_cmd_t              dc;
    logic                   selected;
    logic [3:0]             bl;
    logic                   burstEnd;
    wire [(1<<BANK_W)-1:0]  openNext;

    // pins registered by the controller are sampled on the next sys_clk edge
    always_comb begin
        selected = !bus.csN;
        dc = SDCD_ILL;
        if (s_q.ckePrev && bus.cke) begin
            if (!selected) begin
                dc = SDCD_DES;
            end else begin
                case ({bus.rasN, bus.casN, bus.weN})
                    3'b000: dc = SDCD_MRS;
                    3'b001: dc = SDCD_REF;
                    3'b010: dc = bus.addr[AP_BIT] ? SDCD_PREA : SDCD_PRE;
                    3'b011: dc = SDCD_ACT;
                    3'b100: dc = bus.addr[AP_BIT] ? SDCD_WRA : SDCD_WR;
                    3'b101: dc = bus.addr[AP_BIT] ? SDCD_RDA : SDCD_RD;
                    3'b110: dc = bus.addr[AP_BIT] ? SDCD_ZQCL : SDCD_ZQCS;
                    3'b111: dc = SDCD_NOP;
                    default: dc = SDCD_ILL;
                endcase
            end
        end else if (s_q.ckePrev && !bus.cke) begin
            if (selected && {bus.rasN, bus.casN, bus.weN} == 3'b001) begin
                dc = SDCD_SRE;
            end else begin
                dc = SDCD_PDE;
            end
        end else if (!s_q.ckePrev && bus.cke) begin
            // exit keyed on cke alone; strobes may float while asleep
            // the exit still needs sys_clk running when cke rises
            dc = (s_q.pstate == SDCD_ST_SR) ? SDCD_SRX : SDCD_PDX;
        end else begin
            dc = SDCD_ILL;
        end

        if (otfEnable) begin
            bl = bus.addr[OTF_BIT] ? BURST_BL8 : BURST_BC4;
        end else begin
            bl = fixedChop ? BURST_BC4 : BURST_BL8;
        end
    end

    // last beat of a burst that asked for auto-precharge
    assign burstEnd = (s_q.beats == BURST_ONE) && s_q.preAtEnd;

    // per-bank open flag; an activate wins over a close in one cycle
    for (genvar b = 0; b < (1 << BANK_W); b++) begin : g_bank
        logic hitCmd;
        logic hitEnd;
        logic openB;
        assign hitCmd = (bus.bank == BANK_W'(b));
        assign hitEnd = burstEnd && (s_q.preBank == BANK_W'(b));
        always_comb begin
            if (dc == SDCD_ACT && hitCmd) begin
                openB = 1'b1;
            end else if (dc == SDCD_PREA) begin
                openB = 1'b0;
            end else if (dc == SDCD_PRE && hitCmd) begin
                openB = 1'b0;
            end else if (hitEnd) begin
                openB = 1'b0;
            end else begin
                openB = s_q.open[b];
            end
        end
        assign openNext[b] = openB;
    end : g_bank

    // whole decoder state: one copy filled here, flopped below
    always_comb begin
        s_d = s_q;
        s_d.ckePrev = bus.cke;
        s_d.valid = 1'b0;
        if (s_q.beats != 4'h0) begin
            s_d.beats = s_q.beats - BURST_ONE;
            if (burstEnd) begin
                s_d.preAtEnd = 1'b0;
            end
        end
        if (dc != SDCD_ILL || !s_q.ckePrev) begin
            s_d.cmd = dc;
            s_d.valid = (dc != SDCD_ILL);
            s_d.bank = bus.bank;
            s_d.addr = bus.addr;
            s_d.autoPre = bus.addr[AP_BIT];
            s_d.burst = 4'h0;
        end
        // bank flags come from the per-bank loop above
        s_d.open = openNext;
        case (dc)
            SDCD_WR, SDCD_WRA, SDCD_RD, SDCD_RDA: begin
                // a new burst while one runs is refused: no interruption
                if (s_q.beats == 4'h0) begin
                    s_d.burst = bl;
                    s_d.beats = bl;
                    s_d.preAtEnd = bus.addr[AP_BIT];
                    s_d.preBank = bus.bank;
                end
            end
            SDCD_SRE: s_d.pstate = SDCD_ST_SR;
            SDCD_PDE: s_d.pstate = SDCD_ST_PD;
            SDCD_SRX, SDCD_PDX: s_d.pstate = SDCD_ST_IDLE;
            default: s_d.pstate = s_q.pstate;
        endcase
        // termination follows the pin except in self refresh
        s_d.odtOn = bus.odt && (s_d.pstate != SDCD_ST_SR);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // cmdValid is high for nop and deselect too, both are decoded
    assign cmdOut     = s_q.cmd;
    assign cmdValid   = s_q.valid;
    assign cmdBank    = s_q.bank;
    assign cmdAddr    = s_q.addr;
    assign cmdAutoPre = s_q.autoPre;
    assign cmdBurst   = s_q.burst;
    assign burstBusy  = (s_q.beats != 4'h0);
    assign powerState = s_q.pstate;
    assign odtActive  = s_q.odtOn;
    assign bankOpen   = s_q.open;
    // COL_W documents the column field inside cmdAddr
endmodule : sdcd_decoder

/* File: hdl/sdcd_pkg.sv */
// package: command codes, decoder states and timing constants
package sdcd_pkg;
    localparam int BANK_W_DEF = 3;
    localparam int ROW_W_DEF  = 14;
    localparam int COL_W_DEF  = 10;
    localparam int AP_BIT     = 10;
    localparam int OTF_BIT    = 12;
    localparam int SRX_WR_WAIT_NCK = 512;
    localparam logic [3:0] BURST_BL8 = 4'h8;
    localparam logic [3:0] BURST_BC4 = 4'h4;
    localparam logic [3:0] BURST_ONE = 4'h1;

    typedef enum logic [4:0] {
        SDCD_DES   = 5'h00,
        SDCD_NOP   = 5'h01,
        SDCD_MRS   = 5'h02,
        SDCD_REF   = 5'h03,
        SDCD_SRE   = 5'h04,
        SDCD_SRX   = 5'h05,
        SDCD_PRE   = 5'h06,
        SDCD_PREA  = 5'h07,
        SDCD_ACT   = 5'h08,
        SDCD_WR    = 5'h09,
        SDCD_WRA   = 5'h0A,
        SDCD_RD    = 5'h0B,
        SDCD_RDA   = 5'h0C,
        SDCD_PDE   = 5'h0D,
        SDCD_PDX   = 5'h0E,
        SDCD_ZQCL  = 5'h0F,
        SDCD_ZQCS  = 5'h10,
        SDCD_ILL   = 5'h11
    } sdcd_cmd_t;

    typedef enum logic [1:0] {
        SDCD_ST_IDLE = 2'b00,
        SDCD_ST_PD   = 2'b01,
        SDCD_ST_SR   = 2'b10
    } sdcd_state_t;
endpackage : sdcd_pkg

/* File: verification/sdcd_bus_asserts.sv */
// checker: controller-side timing and encoding rules on the command bus
`timescale 1ns/1ns
module sdcd_bus_asserts #(
    parameter int SRX_WAIT = 512
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        csN,
    input wire logic        rasN,
    input wire logic        casN,
    input wire logic        weN,
    input wire logic        cke,
    input wire logic [2:0]  bank,
    input wire logic [13:0] addr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire isNop = !csN && rasN && casN && weN;
    wire isRef = !csN && !rasN && !casN && weN;
    wire isAct = !csN && !rasN && casN && weN && cke;
    wire isPre = !csN && !rasN && casN && !weN && cke;
    wire isCol = !csN && rasN && !casN && cke;
    logic       prevCkeQ;
    logic       inSrQ;
    logic [9:0] gapQ;
    logic [7:0] openQ;
    // gap saturates so a long idle run never wraps into a false refusal
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prevCkeQ <= 1'b1;
            inSrQ    <= 1'b0;
            gapQ     <= 10'h3FF;
            openQ    <= 8'h00;
        end else begin
            prevCkeQ <= cke;
            if (!cke && prevCkeQ && isRef) inSrQ <= 1'b1;
            if (cke && !prevCkeQ) inSrQ <= 1'b0;
            if (cke && !prevCkeQ && inSrQ) gapQ <= 10'h000;
            else if (gapQ != 10'h3FF) gapQ <= gapQ + 10'h001;
            if (isAct) openQ[bank] <= 1'b1;
            if (isPre && addr[10]) openQ <= 8'h00;
            else if (isPre || (isCol && addr[10])) openQ[bank] <= 1'b0;
        end
    end
    property p_reset_nop;
        $rose(rst_n) |-> cke && isNop;
    endproperty
    a_reset_nop: assert property (p_reset_nop)
        else $error("bus not idle nop after reset");
    property p_pde_nop;
        $fell(cke) && !isRef |-> isNop || csN;
    endproperty
    a_pde_nop: assert property (p_pde_nop)
        else $error("power-down entry with a command");
    property p_cke_fall_enc;
        $fell(cke) && !csN |-> weN && (rasN == casN);
    endproperty
    a_cke_fall_enc: assert property (p_cke_fall_enc)
        else $error("cke fall with illegal encoding");
    property p_exit_nop;
        $rose(cke) |-> isNop || csN;
    endproperty
    a_exit_nop: assert property (p_exit_nop)
        else $error("cke rise with a command");
    property p_srx_write;
        isCol && !weN |-> int'(gapQ) + 1 >= SRX_WAIT;
    endproperty
    a_srx_write: assert property (p_srx_write)
        else $error("write too soon after self-refresh exit");
    property p_sre_idle;
        !cke && prevCkeQ && isRef |-> openQ == 8'h00;
    endproperty
    a_sre_idle: assert property (p_sre_idle)
        else $error("self-refresh entry with a bank open");
    c_sre: cover property (!cke && prevCkeQ && isRef);
    c_srx: cover property (cke && !prevCkeQ && inSrQ);
    c_write: cover property (isCol && !weN);
endmodule : sdcd_bus_asserts

/* File: verification/sdram_command_decoder_bench.sv */
// bench: controller and decoder joined over the command bus
`timescale 1ns/1ns
module sdram_command_decoder_bench;
    import sdcd_pkg::*;
    localparam int WAIT = 8;
    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    sdcd_cmd_t   reqCmd    = SDCD_NOP;
    logic        reqValid  = 1'b0;
    logic [2:0]  reqBank   = 3'h0;
    logic [13:0] reqAddr   = 14'h0000;
    logic        reqOdt    = 1'b0;
    logic        banksIdle = 1'b1;
    logic        otfEnable = 1'b0;
    logic        fixedChop = 1'b0;
    logic        reqReady, cmdValid, cmdAutoPre, burstBusy, odtActive;
    sdcd_cmd_t   cmdOut;
    sdcd_state_t powerState;
    logic [2:0]  cmdBank;
    logic [13:0] cmdAddr;
    logic [3:0]  cmdBurst;
    logic [7:0]  bankOpen;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          gap;
    sdcd_bus_if sdcd_bus_if_i ();
    wire [3:0]   busPins = {sdcd_bus_if_i.csN, sdcd_bus_if_i.rasN,
                            sdcd_bus_if_i.casN, sdcd_bus_if_i.weN};
    sdcd_controller #(.SRX_WAIT(WAIT)) sdcd_controller_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus(sdcd_bus_if_i),
        .reqCmd(reqCmd), .reqValid(reqValid), .reqBank(reqBank),
        .reqAddr(reqAddr), .reqOdt(reqOdt), .banksIdle(banksIdle),
        .reqReady(reqReady));
    sdcd_decoder sdcd_decoder_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus(sdcd_bus_if_i),
        .otfEnable(otfEnable), .fixedChop(fixedChop), .cmdOut(cmdOut),
        .cmdValid(cmdValid), .cmdBank(cmdBank), .cmdAddr(cmdAddr),
        .cmdAutoPre(cmdAutoPre), .cmdBurst(cmdBurst),
        .burstBusy(burstBusy), .powerState(powerState),
        .odtActive(odtActive), .bankOpen(bankOpen));
    sdcd_bus_asserts #(.SRX_WAIT(WAIT)) sdcd_bus_asserts_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .csN(sdcd_bus_if_i.csN),
        .rasN(sdcd_bus_if_i.rasN), .casN(sdcd_bus_if_i.casN),
        .weN(sdcd_bus_if_i.weN), .cke(sdcd_bus_if_i.cke),
        .bank(sdcd_bus_if_i.bank), .addr(sdcd_bus_if_i.addr));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // entered just after an edge; ready is read mid-cycle, stable by then
    task automatic issue(input sdcd_cmd_t c, input logic [2:0] b,
                         input logic [13:0] a, input logic take);
        logic ok;
        ok = 1'b0;
        reqCmd = c;
        reqBank = b;
        reqAddr = a;
        reqValid = 1'b1;
        gap = 0;
        while (!ok && gap < 40) begin
            @(negedge sys_clk);
            ok = (reqReady === 1'b1);
            @(posedge sys_clk);
            #5;
            gap++;
        end
        reqValid = 1'b0;
        chk("taken", 16'(ok), 16'(take));
        if (ok) begin
            ok = 1'b0;
            for (int i = 0; i < 4 && !ok; i++) begin
                @(posedge sys_clk);
                #5;
                ok = (cmdValid === 1'b1);
            end
            chk("valid", 16'(ok), 16'h1);
            chk("cmd", 16'(cmdOut), 16'(c));
            chk("idle pins", 16'(busPins), 16'h0007);
            chk("idle addr", 16'(sdcd_bus_if_i.addr), 16'h0000);
        end
    endtask : issue
    task automatic t_decode();
        sdcd_cmd_t   cs [8] = '{SDCD_MRS, SDCD_ACT, SDCD_PRE, SDCD_PREA,
                                SDCD_REF, SDCD_ZQCL, SDCD_ZQCS, SDCD_DES};
        logic [13:0] as [8] = '{14'h0A5C, 14'h1234, 14'h0000, 14'h0400,
                                14'h0000, 14'h0400, 14'h0000, 14'h0400};
        for (int i = 0; i < 8; i++) begin
            issue(cs[i], 3'(i), as[i], 1'b1);
            if (i < 3) chk("bank", 16'(cmdBank), 16'(i));
            if (i == 0) chk("op", 16'(cmdAddr), 16'h0A5C);
            if (i == 1) chk("open", 16'(bankOpen), 16'h02);
            if (i == 3) chk("pra", 16'(bankOpen), 16'h00);
            if (i == 7) chk("des", 16'(bankOpen), 16'h00);
        end
    endtask : t_decode
    task automatic t_burst();
        sdcd_cmd_t   cs [6] = '{SDCD_RD, SDCD_WR, SDCD_RD, SDCD_WR,
                                SDCD_RDA, SDCD_WRA};
        logic [13:0] as [6] = '{14'h0000, 14'h0000, 14'h0000, 14'h1000,
                                14'h1400, 14'h0400};
        logic [3:0]  bl [6] = '{4'h8, 4'h4, 4'h4, 4'h8, 4'h8, 4'h4};
        logic [5:0]  otf = 6'b111100;
        logic [5:0]  chop = 6'b000010;
        int          n;
        issue(SDCD_ACT, 3'h0, 14'h0000, 1'b1);
        issue(SDCD_ACT, 3'h3, 14'h0000, 1'b1);
        for (int i = 0; i < 6; i++) begin
            otfEnable = otf[i];
            fixedChop = chop[i];
            issue(cs[i], (i == 5) ? 3'h3 : 3'h0, as[i], 1'b1);
            chk("burst", 16'(cmdBurst), 16'(bl[i]));
            chk("ap", 16'(cmdAutoPre), 16'(as[i][10]));
            n = (i == 0) ? 2 : 0;
            if (i == 0) begin
                issue(SDCD_RD, 3'h0, 14'h0000, 1'b1);
                chk("cut", 16'(cmdBurst), 16'h0);
            end
            // controller idles in nop meanwhile, so the count covers it
            while (burstBusy === 1'b1 && n < 12) begin
                @(posedge sys_clk);
                #5;
                n++;
            end
            chk("beats", 16'(n), 16'(bl[i]));
        end
        chk("closed", 16'(bankOpen), 16'h00);
    endtask : t_burst
    task automatic t_power();
        reqOdt = 1'b1;
        issue(SDCD_PDE, 3'h0, 14'h0000, 1'b1);
        chk("pd", 16'(powerState), 16'(SDCD_ST_PD));
        issue(SDCD_PDX, 3'h0, 14'h0000, 1'b1);
        chk("pdx", 16'(powerState), 16'(SDCD_ST_IDLE));
        banksIdle = 1'b0;
        issue(SDCD_SRE, 3'h0, 14'h0000, 1'b0);
        banksIdle = 1'b1;
        issue(SDCD_SRE, 3'h0, 14'h0000, 1'b1);
        chk("sr", 16'(powerState), 16'(SDCD_ST_SR));
        chk("odt sr", 16'(odtActive), 16'h0);
        issue(SDCD_SRX, 3'h0, 14'h0000, 1'b1);
        chk("srx", 16'(powerState), 16'(SDCD_ST_IDLE));
        issue(SDCD_WR, 3'h0, 14'h0000, 1'b1);
        chk("wait", 16'(gap >= WAIT - 2), 16'h1);
        chk("odt", 16'(odtActive), 16'h1);
    endtask : t_power
    initial begin
        repeat (12) @(posedge sys_clk);
        #5;
        rst_n = 1'b1;
        t_decode();
        t_burst();
        t_power();
        test_done();
    end
endmodule : sdram_command_decoder_bench
